// >>> rtl/iao_pkg.sv
package iao_pkg;
  // Instruction field positions
  localparam int OpHi = 31;
  localparam int OpLo = 30;
  localparam int RdHi = 29;
  localparam int RdLo = 25;
  localparam int ExtHi = 24;
  localparam int ExtLo = 19;
  localparam int SrcAHi = 18;
  localparam int SrcALo = 14;
  localparam int ImmSelBit = 13;
  localparam int ImmHi = 12;
  localparam int SrcBHi = 4;
  localparam int ShHi = 4;
  localparam int FlagSetBit = 4;
  localparam logic [1:0] OpClassArith = 2'h2;
  // Opcode extension codes
  localparam logic [5:0] ExtAdd = 6'h00;
  localparam logic [5:0] ExtAddF = 6'h10;
  localparam logic [5:0] ExtAddC = 6'h08;
  localparam logic [5:0] ExtAddCF = 6'h18;
  localparam logic [5:0] ExtSub = 6'h04;
  localparam logic [5:0] ExtSubF = 6'h14;
  localparam logic [5:0] ExtSubC = 6'h0c;
  localparam logic [5:0] ExtSubCF = 6'h1c;
  localparam logic [5:0] ExtTagAdd = 6'h20;
  localparam logic [5:0] ExtTagAddTrap = 6'h22;
  localparam logic [5:0] ExtTagSub = 6'h21;
  localparam logic [5:0] ExtTagSubTrap = 6'h23;
  localparam logic [5:0] ExtMulStep = 6'h24;
  localparam logic [5:0] ExtConj = 6'h01;
  localparam logic [5:0] ExtConjInv = 6'h05;
  localparam logic [5:0] ExtDisj = 6'h02;
  localparam logic [5:0] ExtDisjInv = 6'h06;
  localparam logic [5:0] ExtXor = 6'h03;
  localparam logic [5:0] ExtXnor = 6'h07;
  localparam logic [5:0] ExtShl = 6'h25;
  localparam logic [5:0] ExtShrl = 6'h26;
  localparam logic [5:0] ExtShra = 6'h27;
  // Flag vector order {n,z,v,c}
  localparam int FlagN = 3;
  localparam int FlagZ = 2;
  localparam int FlagV = 1;
  localparam int FlagC = 0;
  localparam logic [3:0] FlagsReset = 4'h0;
  localparam logic [31:0] MulRegReset = 32'h0;
  localparam logic [31:0] WordZero = 32'h0;
  localparam logic [1:0] TagZero = 2'h0;
  // Operation classes
  typedef enum logic [2:0] {
    IaoAdd, IaoSub, IaoMul, IaoLogic, IaoShift, IaoNone
  } iao_cls_t;
endpackage : iao_pkg

// >>> rtl/iao_alu.sv
// Functional notes
// - Operand B: register or sign-extended immediate
// - Add family decoded from extension codes
// - Carry variants add the state carry flag
// - Flag adds update flags, others do not
// - Tag overflow: low tag bits or overflow
// - Tagged add decoded, trapping and plain
// - Trapping tagged add overflow: trap, no writes
// - Trapping tagged add ok: flags, V cleared
// - Plain tagged add sets V, always writes
// - Subtract, extended forms also subtract carry
// - Flag subtracts update all flags
// - Tagged subtract decoded, trapping and plain
// - Trapping tagged subtract traps, else writes
// - Plain tagged subtract sets V, writes
// - Multiply step shifts in N xor V
// - Multiply step adds operand when multiplier LSB
// - Multiply step writes sum and flags
// - Multiplier shifts right taking A's LSB
// - Six bitwise logical operations
// - Logical codes; bit four selects flags
// - Flag logical ops update flags
// - Shift amount is low five bits
// - Left shift fills zeros
// - Right shifts logical and arithmetic
// - Arithmetic fills sign; shifts keep flags
`timescale 1ns/1ps
module iao_alu
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn, // Freezes all state when low
  input wire logic instValid, // Instruction issue strobe
  input wire logic [31:0] instWord, // Format-3 instruction
  input wire logic [31:0] srcAVal, // Register file read A
  input wire logic [31:0] srcBVal, // Register file read B
  output logic [4:0] srcAAddr, // Read address A
  output logic [4:0] srcBAddr, // Read address B
  output logic rdWrEn_q, // Destination write pulse
  output logic [4:0] rdAddr_q, // Destination index
  output logic [31:0] rdData_q, // Destination data
  output logic tagTrap_q, // Tag overflow trap pulse
  output logic illegalOp_q, // Unknown extension or op class pulse
  output logic [3:0] flags_q, // State word n,z,v,c
  output logic [31:0] mulReg_q // Multiplier register
);
  import iao_pkg::*;

  // Field slicing
  logic [5:0] ext;
  logic immSel;
  logic isFmt3;
  logic [4:0] rdIdx;
  logic [31:0] immSigned;
  logic [31:0] opB;
  logic [4:0] shAmt;
  assign isFmt3 = instWord[OpHi:OpLo] == OpClassArith;
  assign ext = instWord[ExtHi:ExtLo];
  assign rdIdx = instWord[RdHi:RdLo];
  assign immSel = instWord[ImmSelBit];
  assign srcAAddr = instWord[SrcAHi:SrcALo];
  assign srcBAddr = instWord[SrcBHi:0];
  // Sign-extend 13-bit immediate
  assign immSigned = {{(31 - ImmHi){instWord[ImmHi]}}, instWord[ImmHi:0]};
  assign opB = immSel ? immSigned : srcBVal;
  assign shAmt = opB[ShHi:0];

  // Decode into class and modifiers
  iao_cls_t cls;
  logic useCarry;
  logic setFlags;
  logic isTagged;
  logic trapOnOv;
  always_comb begin
    cls = IaoNone;
    useCarry = 1'b0;
    setFlags = 1'b0;
    isTagged = 1'b0;
    trapOnOv = 1'b0;
    unique case (ext)
      // Add family
      ExtAdd: cls = IaoAdd;
      ExtAddF: begin
        cls = IaoAdd;
        setFlags = 1'b1;
      end
      ExtAddC: begin
        cls = IaoAdd;
        useCarry = 1'b1;
      end
      ExtAddCF: begin
        cls = IaoAdd;
        useCarry = 1'b1;
        setFlags = 1'b1;
      end
      // Subtract family
      ExtSub: cls = IaoSub;
      ExtSubF: begin
        cls = IaoSub;
        setFlags = 1'b1;
      end
      ExtSubC: begin
        cls = IaoSub;
        useCarry = 1'b1;
      end
      ExtSubCF: begin
        cls = IaoSub;
        useCarry = 1'b1;
        setFlags = 1'b1;
      end
      // Tagged forms
      ExtTagAdd, ExtTagAddTrap: begin
        cls = IaoAdd;
        setFlags = 1'b1;
        isTagged = 1'b1;
        trapOnOv = ext == ExtTagAddTrap;
      end
      ExtTagSub, ExtTagSubTrap: begin
        cls = IaoSub;
        setFlags = 1'b1;
        isTagged = 1'b1;
        trapOnOv = ext == ExtTagSubTrap;
      end
      ExtMulStep: begin
        cls = IaoMul;
        setFlags = 1'b1;
      end
      // Logical, bit four selects flag update
      ExtConj, ExtConjInv, ExtDisj, ExtDisjInv, ExtXor, ExtXnor,
      ExtXor | 6'h10, ExtConj | 6'h10, ExtConjInv | 6'h10,
      ExtDisj | 6'h10, ExtDisjInv | 6'h10, ExtXnor | 6'h10: begin
        cls = IaoLogic;
        setFlags = ext[FlagSetBit];
      end
      ExtShl, ExtShrl, ExtShra: cls = IaoShift;
      default: cls = IaoNone;
    endcase
    // Other op classes: no modifier may leak into a trap or flag write
    if (!isFmt3) begin
      cls = IaoNone;
      useCarry = 1'b0;
      setFlags = 1'b0;
      isTagged = 1'b0;
      trapOnOv = 1'b0;
    end
  end

  // Adder shared by add, subtract and multiply step
  logic [31:0] addA;
  logic [31:0] addB;
  logic carryIn;
  logic [32:0] sum;
  logic [31:0] mulShifted;
  logic isSub;
  assign isSub = cls == IaoSub;
  // Partial product shifted with N xor V on top
  assign mulShifted = {flags_q[FlagN] ^ flags_q[FlagV], srcAVal[31:1]};
  always_comb begin
    addA = srcAVal;
    addB = opB;
    carryIn = 1'b0;
    if (cls == IaoMul) begin
      addA = mulShifted;
      addB = mulReg_q[0] ? opB : WordZero;
    end else if (isSub) begin
      // A - B - c as A + ~B + ~c
      addB = ~opB;
      carryIn = ~(useCarry & flags_q[FlagC]);
    end else begin
      carryIn = useCarry & flags_q[FlagC];
    end
  end
  assign sum = {1'b0, addA} + {1'b0, addB} + {32'h0, carryIn};

  // Arithmetic flags
  logic arithOv;
  logic arithC;
  logic tagOv;
  assign arithOv = (addA[31] == addB[31]) && (sum[31] != addA[31]);
  assign arithC = isSub ? ~sum[32] : sum[32]; // Borrow for subtract
  // Tag bits of either operand, or overflow
  assign tagOv = (srcAVal[1:0] != TagZero) || (opB[1:0] != TagZero)
      || arithOv;

  // Logical unit
  logic [31:0] logicRes;
  always_comb begin
    unique case (ext[2:0])
      ExtConj[2:0]: logicRes = srcAVal & opB;
      ExtConjInv[2:0]: logicRes = srcAVal & ~opB;
      ExtDisj[2:0]: logicRes = srcAVal | opB;
      ExtDisjInv[2:0]: logicRes = srcAVal | ~opB;
      ExtXor[2:0]: logicRes = srcAVal ^ opB;
      ExtXnor[2:0]: logicRes = ~(srcAVal ^ opB);
      default: logicRes = WordZero;
    endcase
  end

  // Shifter, zero amount passes operand
  logic [31:0] shiftRes;
  always_comb begin
    unique case (ext)
      ExtShl: shiftRes = srcAVal << shAmt;
      ExtShrl: shiftRes = srcAVal >> shAmt;
      ExtShra: shiftRes = $unsigned($signed(srcAVal) >>> shAmt);
      default: shiftRes = srcAVal;
    endcase
  end

  // Result and next flags
  logic [31:0] result;
  logic [3:0] newFlags;
  logic doWrite;
  logic doFlags;
  logic doTrap;
  always_comb begin
    result = sum[31:0];
    newFlags = {sum[31], sum[31:0] == WordZero, arithOv, arithC};
    if (cls == IaoLogic) begin
      result = logicRes;
      newFlags = {logicRes[31], logicRes == WordZero, 2'b00};
    end else if (cls == IaoShift) begin
      result = shiftRes;
    end
    if (isTagged) begin
      newFlags[FlagV] = tagOv & ~trapOnOv;
    end
    doTrap = instValid && isTagged && trapOnOv && tagOv;
    doWrite = instValid && cls != IaoNone && !doTrap;
    doFlags = doWrite && setFlags;
  end

  // Destination write port
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdWrEn_q <= 1'b0;
      rdAddr_q <= 5'h00;
      rdData_q <= WordZero;
      tagTrap_q <= 1'b0;
      illegalOp_q <= 1'b0;
    end else if (clkEn) begin
      rdWrEn_q <= doWrite;
      tagTrap_q <= doTrap;
      illegalOp_q <= instValid && cls == IaoNone;
      if (doWrite) begin
        rdAddr_q <= rdIdx;
        rdData_q <= result;
      end
    end
  end

  // Condition flags of the state word
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flags_q <= FlagsReset;
    end else if (clkEn && doFlags) begin
      flags_q <= newFlags;
    end
  end

  // Multiplier register shift
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mulReg_q <= MulRegReset;
    end else if (clkEn && instValid && cls == IaoMul) begin
      mulReg_q <= {srcAVal[0], mulReg_q[31:1]};
    end
  end

  // Checks
  trap_blocks_write_a: assert property (@(posedge core_clk)
    disable iff (reset) tagTrap_q |-> !rdWrEn_q)
    else $error("trap with destination write");
  trap_keeps_flags_a: assert property (@(posedge core_clk)
    disable iff (reset) tagTrap_q |-> $stable(flags_q))
    else $error("flags changed on trap");
  plain_add_flags_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && instValid && isFmt3 && ext == ExtAdd
    |=> $stable(flags_q))
    else $error("plain add touched flags");
  shift_keeps_flags_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && instValid && cls == IaoShift
    |=> $stable(flags_q))
    else $error("shift touched flags");
  tag_ov_set_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && instValid && isFmt3 && ext == ExtTagAdd
    && srcAVal[0] |=> flags_q[FlagV] && rdWrEn_q)
    else $error("tagged add missed tag overflow");
  tagtv_clear_v_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && instValid && isFmt3
    && ext == ExtTagAddTrap && !tagOv |=> !flags_q[FlagV] && rdWrEn_q)
    else $error("trapping tagged add left v set");
  mul_shift_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && instValid && cls == IaoMul
    |=> mulReg_q[31] == $past(srcAVal[0]))
    else $error("multiplier top bit wrong");
  add_result_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && instValid && isFmt3 && ext == ExtAdd
    |=> rdData_q == $past(srcAVal) + $past(opB))
    else $error("add result wrong");
  logic_cv_clear_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && doFlags && cls == IaoLogic
    |=> flags_q[FlagC:0] == 1'b0 && !flags_q[FlagV])
    else $error("logical op left c or v");
  // Result, write and flag checks per operation class
  illegal_no_write_a: assert property (@(posedge core_clk)
    disable iff (reset) illegalOp_q |-> !rdWrEn_q && !tagTrap_q)
    else $error("undecoded word wrote or trapped");
  sub_result_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && instValid && isFmt3 && ext == ExtSub
    |=> rdData_q == $past(srcAVal) - $past(opB))
    else $error("subtract result wrong");
  addc_result_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && instValid && isFmt3 && ext == ExtAddC
    |=> rdData_q == $past(srcAVal) + $past(opB)
    + {31'h0, $past(flags_q[FlagC])})
    else $error("carry add result wrong");
  mul_skip_add_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && instValid && cls == IaoMul && !mulReg_q[0]
    |=> rdData_q == $past(mulShifted))
    else $error("multiply step added with multiplier bit clear");
  shl_result_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && instValid && isFmt3 && ext == ExtShl
    |=> rdData_q == $past(srcAVal) << $past(shAmt))
    else $error("left shift result wrong");
  conj_result_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && instValid && isFmt3 && ext == ExtConj
    |=> rdData_q == ($past(srcAVal) & $past(opB)))
    else $error("conjunction result wrong");
  plain_logic_flags_a: assert property (@(posedge core_clk)
    disable iff (reset) clkEn && instValid && isFmt3 && ext == ExtConj
    |=> $stable(flags_q))
    else $error("plain logical op touched flags");

  // Scenario coverage
  cov_trap_c: cover property (@(posedge core_clk) tagTrap_q);
  cov_mul_c: cover property (@(posedge core_clk)
    clkEn && instValid && cls == IaoMul && mulReg_q[0]);
  cov_sra_c: cover property (@(posedge core_clk)
    clkEn && instValid && isFmt3 && ext == ExtShra && srcAVal[31]);
  cov_tag_sub_c: cover property (@(posedge core_clk)
    clkEn && instValid && isFmt3 && ext == ExtTagSub);
endmodule : iao_alu

// >>> tb/iao_regfile.sv
`timescale 1ns/1ps
// Register file stand-in with write-through reads
module iao_regfile (
  input wire logic core_clk,
  input wire logic [4:0] addrA,
  input wire logic [4:0] addrB,
  input wire logic wrEn,
  input wire logic [4:0] wrAddr,
  input wire logic [31:0] wrData,
  output logic [31:0] dataA,
  output logic [31:0] dataB
);
  logic [31:0] mem [32]; // Register storage
  // A write landing this cycle is seen at once
  assign dataA = (wrEn && wrAddr == addrA) ? wrData : mem[addrA];
  assign dataB = (wrEn && wrAddr == addrB) ? wrData : mem[addrB];
  // Write on the rising edge
  always @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end
endmodule : iao_regfile

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import iao_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic instValid = 1'b0;
  logic [31:0] instWord = 32'h0;
  logic [31:0] srcAVal, srcBVal, rdData_q, mulReg_q, w, snap;
  logic [4:0] srcAAddr, srcBAddr, rdAddr_q, eRd;
  logic rdWrEn_q, tagTrap_q, illegalOp_q, eWr, eTrap, eIll;
  logic [3:0] flags_q;
  logic [3:0] fl = 4'h0; // Expected flags
  logic [31:0] y = 32'h0; // Expected multiplier
  logic [31:0] eData; // Expected write data
  logic [31:0] regs [32]; // Register mirror
  logic [31:0] corner [10]; // Hand-picked cases
  int fail_count = 0;
  int check_count = 0;

  // Clock of 40 ns
  always #20 core_clk = ~core_clk;

  iao_alu u_dut (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
    .instValid(instValid), .instWord(instWord), .srcAVal(srcAVal),
    .srcBVal(srcBVal), .srcAAddr(srcAAddr), .srcBAddr(srcBAddr),
    .rdWrEn_q(rdWrEn_q), .rdAddr_q(rdAddr_q), .rdData_q(rdData_q),
    .tagTrap_q(tagTrap_q), .illegalOp_q(illegalOp_q),
    .flags_q(flags_q), .mulReg_q(mulReg_q));

  iao_regfile u_rf (.core_clk(core_clk), .addrA(srcAAddr),
    .addrB(srcBAddr), .wrEn(rdWrEn_q), .wrAddr(rdAddr_q),
    .wrData(rdData_q), .dataA(srcAVal), .dataB(srcBVal));

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : check

  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // Build an instruction word
  function automatic logic [31:0] mk(logic [5:0] x, logic [4:0] rd,
    logic [4:0] ra, logic [13:0] op2);
    return {OpClassArith, rd, x, ra, op2};
  endfunction : mk

  // Work out the expected outcome
  task automatic predict(input logic [31:0] i);
    logic [5:0] x;
    logic [31:0] a, b, r;
    logic cy, v, cin, sf;
    x = i[24:19];
    eIll = i[31:30] != OpClassArith;
    a = regs[i[18:14]];
    b = i[13] ? {{19{i[12]}}, i[12:0]} : regs[i[4:0]];
    cin = x[3] & fl[FlagC];
    sf = x[4];
    {cy, v, r} = 34'h0;
    eWr = 1'b1;
    eRd = i[29:25];
    if (x == ExtMulStep && !eIll) begin
      b = y[0] ? b : WordZero;
      y = {a[0], y[31:1]};
      a = {fl[FlagN] ^ fl[FlagV], a[31:1]};
      sf = 1'b1;
    end
    case (x)
      ExtAdd, ExtAddF, ExtAddC, ExtAddCF, ExtTagAdd, ExtTagAddTrap,
      ExtMulStep: begin
        {cy, r} = {1'b0, a} + {1'b0, b} + cin;
        v = (a[31] == b[31]) && (r[31] != a[31]);
      end
      ExtSub, ExtSubF, ExtSubC, ExtSubCF, ExtTagSub,
      ExtTagSubTrap: begin
        {cy, r} = {1'b0, a} - {1'b0, b} - cin;
        v = (a[31] != b[31]) && (r[31] != a[31]);
      end
      6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h07, 6'h11, 6'h12, 6'h13,
      6'h15, 6'h16, 6'h17: begin
        case (x[2:0])
          3'h1: r = a & b;
          3'h5: r = a & ~b;
          3'h2: r = a | b;
          3'h6: r = a | ~b;
          3'h3: r = a ^ b;
          default: r = ~(a ^ b);
        endcase
      end
      ExtShl: r = a << b[4:0];
      ExtShrl: r = a >> b[4:0];
      ExtShra: r = $signed(a) >>> b[4:0];
      default: eIll = 1'b1;
    endcase
    if (x[5:2] == 4'h8 && !eIll) begin
      v = v | (|a[1:0]) | (|b[1:0]);
      sf = 1'b1;
      if (x[1] && v) begin
        {eTrap, eWr, sf} = 3'b100;
      end
    end
    if (i[31:30] != OpClassArith) eIll = 1'b1;
    if (eIll) {eWr, sf} = 2'b00;
    if (sf) fl = {r[31], r == WordZero, v, cy};
    if (eWr) regs[eRd] = r;
    eData = r;
  endtask : predict

  // Present one cycle and check its outcome
  task automatic issue(input logic vld, input logic [31:0] i);
    instValid = vld;
    instWord = i;
    #1;
    check(srcAAddr, i[18:14]);
    check(srcBAddr, i[4:0]);
    {eWr, eTrap, eIll} = 3'b000;
    if (vld) predict(i);
    @(negedge core_clk);
    check(rdWrEn_q, eWr);
    check(tagTrap_q, eTrap);
    check(illegalOp_q, eIll);
    check(flags_q, fl);
    check(mulReg_q, y);
    if (eWr) begin
      check(rdAddr_q, eRd);
      check(rdData_q, eData);
    end
  endtask : issue

  // Hang guard
  initial begin
    #4000000;
    fail_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    void'($urandom(88934));
    for (int k = 0; k < 32; k++) begin
      regs[k] = $urandom & (k < 8 ? 32'hffff_fffc : 32'hffff_ffff);
    end
    regs[1] = 32'h7fff_ffff;
    regs[2] = 32'h8000_0000;
    regs[3] = 32'h7fff_fffc;
    regs[4] = 32'h0000_0004;
    u_rf.mem = regs;
    corner = '{mk(ExtAddF, 5'd6, 5'd1, 14'h2001),
      mk(ExtAddCF, 5'd7, 5'd2, 14'h3fff), mk(ExtAddC, 5'd8, 5'd4, 14'h2000),
      mk(ExtTagAddTrap, 5'd9, 5'd3, 14'h2004),
      mk(ExtTagAddTrap, 5'd9, 5'd4, 14'h2004),
      mk(ExtTagSubTrap, 5'd10, 5'd2, 14'h0004),
      mk(ExtShra, 5'd11, 5'd2, 14'h201f), mk(ExtShl, 5'd12, 5'd1, 14'h2020),
      mk(ExtSubCF, 5'd0, 5'd1, 14'h0002), {2'h3, 30'h0}};
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    check({rdWrEn_q, tagTrap_q, illegalOp_q, flags_q}, 32'h0);
    check(mulReg_q, MulRegReset);
    foreach (corner[k]) issue(1'b1, corner[k]);
    for (int k = 0; k < 600; k++) begin
      w = $urandom;
      w[31:30] = ($urandom % 16 == 0) ? 2'h3 : OpClassArith;
      w[24:19] = 6'($urandom_range(40, 0));
      issue(($urandom % 8) != 0, w);
    end
    // Frozen clock enable ignores a valid instruction
    snap = rdData_q;
    clkEn = 1'b0;
    instValid = 1'b1;
    instWord = mk(ExtAddF, 5'd5, 5'd1, 14'h2001);
    repeat (2) @(negedge core_clk);
    check(rdData_q, snap);
    check({rdWrEn_q, tagTrap_q, illegalOp_q}, {eWr, eTrap, eIll});
    check(flags_q, fl);
    check(mulReg_q, y);
    clkEn = 1'b1;
    instValid = 1'b0;
    @(negedge core_clk);
    check({rdWrEn_q, tagTrap_q, illegalOp_q}, 32'h0);
    check(rdData_q, snap);
    stop_test();
  end
endmodule : tb_top
